// file: core/cald_core.sv
// Arithmetic, logic and bit-manipulation datapath of the 16-bit core
// Notes on behaviour
// - Add word or byte operands; the carry variant adds the incoming carry.
// - Subtract word or byte operands; the borrow variant also subtracts carry.
// - Multiply two 16-bit registers, signed or unsigned, into 32 bits.
// - Divide the 16-bit low multiply/divide register by a register.
// - Divide the 32-bit register pair by a 16-bit register, signed/unsigned.
// - Ones complement inverts every bit of a word or byte register.
// - Twos complement replaces a word or byte register by its negation.
// - Bitwise AND, OR and XOR on word or byte operands.
// - Copy a source bit, true or inverted, into a destination bit.
// - Combine two bits with AND, OR or XOR into the destination bit.
// - Compare two bits, report flags, alter neither bit.
// - Modify high or low byte of a word under mask from immediate.
// - Compare word or byte operands; flags only, no write.
// - Compare word data to a register, then decrement it by 1 or 2.
// - Compare word data to a register, then increment it by 1 or 2.
// - Count shifts that normalize a word; store the count in a register.
// - Logical shift of a word register left or right.
// - Rotate a word register left or right.
// - Arithmetic right shift replicates the sign bit.
// - Move a byte into a word with sign or zero extension.
`default_nettype none
module cald_core
	import cald_pkg::*;
(
	input  wire logic      mclk,
	input  wire logic      reset,
	input  wire logic      req_valid,
	input  wire cald_req_s req_i,
	output logic           req_ready,
	output logic           rsp_valid,
	output cald_rsp_s      rsp_o
);
	typedef enum {st_idle, st_divide, st_finish} cald_state_e;

	cald_state_e state_reg;
	cald_state_e state_next;
	cald_rsp_s   rsp_reg;
	cald_rsp_s   simple_rsp;
	cald_rsp_s   div_rsp;
	logic        done_reg;
	logic        ready_reg;
	logic        fire;
	logic        is_div;
	logic        div_signed;
	logic [31:0] quo_reg;
	logic [16:0] rem_reg;
	logic [15:0] dvs_reg;
	logic [4:0]  count_reg;
	logic        neg_q_reg;
	logic        neg_r_reg;
	logic        sgn_reg;
	logic        dvs_zero_reg;
	logic [31:0] dividend;
	logic [16:0] div_trial;

	assign fire = req_valid && ready_reg;
	assign is_div = req_i.op inside {op_div, op_divu, op_divl, op_divlu};
	assign div_signed = req_i.op inside {op_div, op_divl};
	assign req_ready = ready_reg;
	assign rsp_valid = done_reg;
	assign rsp_o = rsp_reg;

	// Returns {overflow, carry-out, result}; byte forms keep the upper byte
	function automatic logic [17:0] add_core(input logic [15:0] x,
			input logic [15:0] y, input logic ci, input logic bm);
		logic [16:0] sw;
		logic [8:0]  sb;
		sw = {1'b0, x} + {1'b0, y} + {16'h0000, ci};
		sb = {1'b0, x[7:0]} + {1'b0, y[7:0]} + {8'h00, ci};
		if (bm) begin
			add_core = {(x[7] == y[7]) && (sb[7] != x[7]), sb[8],
				x[15:8], sb[7:0]};
		end else begin
			add_core = {(x[15] == y[15]) && (sw[15] != x[15]), sw};
		end
	endfunction : add_core

	function automatic logic [15:0] norm_count(input logic [15:0] x);
		logic [15:0] n;
		logic        hit;
		n = CALD_RST_WORD;
		hit = 1'b0;
		for (int i = 15; i >= 0; i--) begin
			if (x[i]) begin
				hit = 1'b1;
			end
			if (!hit) begin
				n = n + CALD_STEP_ONE;
			end
		end
		// An all-zero word cannot be normalized; report no shifts
		if (!hit) begin
			n = CALD_RST_WORD;
		end
		norm_count = n;
	endfunction : norm_count

	logic [17:0] ar;
	logic [16:0] sh;
	logic [31:0] rr;
	logic [31:0] prod;
	logic [15:0] res;
	logic [15:0] step;
	logic [7:0]  fld;
	logic        dbit;
	logic        sbit;
	logic        nbit;
	logic        bm;

	always_comb begin
		simple_rsp = '0;
		bm = req_i.byte_op;
		ar = 18'h00000;
		sh = 17'h00000;
		rr = 32'h0000_0000;
		prod = 32'h0000_0000;
		res = req_i.opa;
		step = CALD_RST_WORD;
		fld = 8'h00;
		dbit = req_i.opa[req_i.dst_bit];
		sbit = req_i.opb[req_i.src_bit];
		nbit = dbit;
		simple_rsp.write_back = 1'b1;
		case (req_i.op)
		op_add, op_addc: begin
			ar = add_core(req_i.opa, req_i.opb,
				req_i.op == op_addc && req_i.cin, bm);
			res = ar[15:0];
			simple_rsp.flags.carry = ar[16];
			simple_rsp.flags.overflow = ar[17];
		end
		// Carry after a subtract is the borrow, hence the inversions
		op_sub, op_subc, op_cmp, op_cmpd1, op_cmpd2, op_cmpi1,
		op_cmpi2: begin
			ar = add_core(req_i.opa, ~req_i.opb,
				!(req_i.op == op_subc && req_i.cin), bm);
			res = ar[15:0];
			simple_rsp.flags.carry = !ar[16];
			simple_rsp.flags.overflow = ar[17];
			if (req_i.op inside {op_cmp, op_cmpd1, op_cmpd2, op_cmpi1,
					op_cmpi2}) begin
				simple_rsp.write_back = 1'b0;
			end
			if (req_i.op inside {op_cmpd1, op_cmpd2, op_cmpi1,
					op_cmpi2}) begin
				bm = 1'b0;
				step = req_i.op inside {op_cmpd1, op_cmpi1} ?
					CALD_STEP_ONE : CALD_STEP_TWO;
				simple_rsp.write_back = 1'b1;
				simple_rsp.result_hi = (req_i.op inside
					{op_cmpd1, op_cmpd2}) ? req_i.opa - step
					: req_i.opa + step;
				simple_rsp.hi_valid = 1'b1;
			end
		end
		op_mul: begin
			prod = $signed(req_i.opa) * $signed(req_i.opb);
			res = prod[15:0];
			simple_rsp.flags.overflow = prod[31:15] != {17{prod[15]}};
		end
		op_mulu: begin
			prod = req_i.opa * req_i.opb;
			res = prod[15:0];
			simple_rsp.flags.overflow = prod[31:16] != 16'h0000;
		end
		op_cpl: begin
			res = bm ? {req_i.opa[15:8], ~req_i.opa[7:0]}
				: ~req_i.opa;
		end
		op_neg: begin
			ar = add_core(bm ? {req_i.opa[15:8], 8'h00} : CALD_RST_WORD,
				~req_i.opa, 1'b1, bm);
			res = ar[15:0];
			simple_rsp.flags.carry = !ar[16];
			simple_rsp.flags.overflow = ar[17];
		end
		op_and: res = req_i.opa & (bm ? {8'hff, req_i.opb[7:0]}
			: req_i.opb);
		op_or: res = req_i.opa | (bm ? {8'h00, req_i.opb[7:0]}
			: req_i.opb);
		op_xor: res = req_i.opa ^ (bm ? {8'h00, req_i.opb[7:0]}
			: req_i.opb);
		op_bclr, op_bset, op_bmov, op_bmovn, op_band, op_bor, op_bxor,
		op_bit_compare_op: begin
			bm = 1'b0;
			case (req_i.op)
			op_bclr: nbit = 1'b0;
			op_bset: nbit = 1'b1;
			op_bmov: nbit = sbit;
			op_bmovn: nbit = !sbit;
			op_band: nbit = dbit & sbit;
			op_bor: nbit = dbit | sbit;
			op_bxor: nbit = dbit ^ sbit;
			default: nbit = dbit;
			endcase
			res[req_i.dst_bit] = nbit;
			simple_rsp.write_back = req_i.op != op_bit_compare_op;
			simple_rsp.result = res;
			// Bit flags describe the operands, not a word result
			simple_rsp.flags.zero = !dbit;
			simple_rsp.flags.negative = dbit ^ sbit;
			simple_rsp.flags.carry = dbit & sbit;
			simple_rsp.flags.overflow = dbit | sbit;
		end
		op_bfldh: begin
			fld = (req_i.opa[15:8] & ~req_i.mask) | (req_i.imm & req_i.mask);
			res = {fld, req_i.opa[7:0]};
			bm = 1'b0;
		end
		op_bfldl: begin
			fld = (req_i.opa[7:0] & ~req_i.mask) | (req_i.imm & req_i.mask);
			res = {req_i.opa[15:8], fld};
			bm = 1'b0;
		end
		op_prior: begin
			res = norm_count(req_i.opa);
			bm = 1'b0;
		end
		op_shl: begin
			sh = {1'b0, req_i.opa} << req_i.opb[3:0];
			res = sh[15:0];
			simple_rsp.flags.carry = sh[16];
			bm = 1'b0;
		end
		op_shr, op_arith_right_shift_op: begin
			if (req_i.op == op_arith_right_shift_op) begin
				sh = 17'($signed({req_i.opa, 1'b0})
					>>> req_i.opb[3:0]);
			end else begin
				sh = {req_i.opa, 1'b0} >> req_i.opb[3:0];
			end
			res = sh[16:1];
			simple_rsp.flags.carry = sh[0];
			bm = 1'b0;
		end
		op_rol: begin
			rr = {req_i.opa, req_i.opa} << req_i.opb[3:0];
			res = rr[31:16];
			simple_rsp.flags.carry = (req_i.opb[3:0] != 4'h0) && res[0];
			bm = 1'b0;
		end
		op_ror: begin
			rr = {req_i.opa, req_i.opa} >> req_i.opb[3:0];
			res = rr[15:0];
			simple_rsp.flags.carry = (req_i.opb[3:0] != 4'h0) && res[15];
			bm = 1'b0;
		end
		op_mov: res = bm ? {req_i.opa[15:8], req_i.opb[7:0]}
			: req_i.opb;
		op_movbs: begin
			res = {{8{req_i.opb[7]}}, req_i.opb[7:0]};
			bm = 1'b0;
		end
		op_movbz: begin
			res = {8'h00, req_i.opb[7:0]};
			bm = 1'b0;
		end
		default: simple_rsp.write_back = 1'b0;
		endcase
		if (!(req_i.op inside {op_bclr, op_bset, op_bmov, op_bmovn, op_band,
				op_bor, op_bxor, op_bit_compare_op})) begin
			simple_rsp.result = res;
			simple_rsp.flags.zero = bm ? res[7:0] == 8'h00
				: res == CALD_RST_WORD;
			simple_rsp.flags.negative = bm ? res[7] : res[15];
		end
		if (req_i.op inside {op_mul, op_mulu}) begin
			simple_rsp.result_hi = prod[31:16];
			simple_rsp.hi_valid = 1'b1;
			simple_rsp.flags.zero = prod == 32'h0000_0000;
			simple_rsp.flags.negative = prod[31];
		end
	end

	// Divide: sign-magnitude restoring loop, one quotient bit per clock
	always_comb begin
		if (req_i.op inside {op_divl, op_divlu}) begin
			dividend = req_i.md_pair;
		end else if (div_signed) begin
			dividend = {{16{req_i.opa[15]}}, req_i.opa};
		end else begin
			dividend = {16'h0000, req_i.opa};
		end
	end

	assign div_trial = {rem_reg[15:0], quo_reg[31]} - {1'b0, dvs_reg};

	always_ff @(posedge mclk) begin
		if (reset) begin
			quo_reg <= CALD_RST_LONG;
			rem_reg <= 17'h00000;
			dvs_reg <= CALD_RST_WORD;
			neg_q_reg <= 1'b0;
			neg_r_reg <= 1'b0;
			sgn_reg <= 1'b0;
			dvs_zero_reg <= 1'b0;
		end else if (fire && is_div) begin
			quo_reg <= (div_signed && dividend[31]) ? ~dividend + 32'h1
				: dividend;
			rem_reg <= 17'h00000;
			dvs_reg <= (div_signed && req_i.opb[15]) ? ~req_i.opb + 16'h1
				: req_i.opb;
			neg_q_reg <= div_signed && (dividend[31] ^ req_i.opb[15]);
			neg_r_reg <= div_signed && dividend[31];
			sgn_reg <= div_signed;
			dvs_zero_reg <= req_i.opb == CALD_RST_WORD;
		end else if (state_reg == st_divide) begin
			if (!div_trial[16]) begin
				rem_reg <= div_trial;
				quo_reg <= {quo_reg[30:0], 1'b1};
			end else begin
				rem_reg <= {rem_reg[15:0], quo_reg[31]};
				quo_reg <= {quo_reg[30:0], 1'b0};
			end
		end
	end

	logic [31:0] q_fix;
	logic [15:0] r_fix;

	always_comb begin
		div_rsp = '0;
		q_fix = neg_q_reg ? ~quo_reg + 32'h1 : quo_reg;
		r_fix = neg_r_reg ? ~rem_reg[15:0] + 16'h1 : rem_reg[15:0];
		div_rsp.result = q_fix[15:0];
		div_rsp.result_hi = r_fix;
		div_rsp.hi_valid = 1'b1;
		div_rsp.write_back = 1'b1;
		div_rsp.flags.zero = q_fix[15:0] == CALD_RST_WORD;
		div_rsp.flags.negative = q_fix[15];
		// A zero divisor or a quotient beyond 16 bits flags overflow
		div_rsp.flags.overflow = dvs_zero_reg || (sgn_reg
			? q_fix[31:15] != {17{q_fix[15]}} : q_fix[31:16] != 16'h0000);
	end

	always_comb begin
		case (state_reg)
		st_idle: state_next = (fire && is_div) ? st_divide : st_idle;
		st_divide: state_next = (count_reg == CALD_DIV_LAST) ? st_finish
			: st_divide;
		st_finish: state_next = st_idle;
		default: state_next = st_idle;
		endcase
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			state_reg <= st_idle;
			count_reg <= 5'h00;
		end else begin
			state_reg <= state_next;
			count_reg <= (state_reg == st_divide) ? count_reg + 5'h01 : 5'h00;
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			rsp_reg <= '0;
			done_reg <= 1'b0;
			ready_reg <= 1'b0;
		end else begin
			ready_reg <= state_next == st_idle;
			done_reg <= (fire && !is_div) || state_reg == st_finish;
			if (state_reg == st_finish) begin
				rsp_reg <= div_rsp;
			end else if (fire && !is_div) begin
				rsp_reg <= simple_rsp;
			end
		end
	end

	add_word_a: assert property (@(posedge mclk) disable iff (reset)
		fire && req_i.op == op_add && !req_i.byte_op |=> done_reg &&
		rsp_reg.result == $past(req_i.opa) + $past(req_i.opb))
		else $error("word add result wrong");
	sub_borrow_a: assert property (@(posedge mclk) disable iff (reset)
		fire && req_i.op == op_subc && !req_i.byte_op |=> rsp_reg.result
		== $past(req_i.opa) - $past(req_i.opb) - {15'h0000, $past(req_i.cin)})
		else $error("subtract with borrow result wrong");
	mul_unsigned_a: assert property (@(posedge mclk) disable iff (reset)
		fire && req_i.op == op_mulu |=> {rsp_reg.result_hi, rsp_reg.result}
		== $past(req_i.opa) * $past(req_i.opb))
		else $error("unsigned product wrong");
	div_quotient_a: assert property (@(posedge mclk) disable iff (reset)
		fire && req_i.op == op_divu && req_i.opb != 16'h0000 |=>
		!done_reg[*8] ##26 done_reg && rsp_reg.result ==
		$past(req_i.opa, 34) / $past(req_i.opb, 34))
		else $error("unsigned divide wrong or late");
	neg_word_a: assert property (@(posedge mclk) disable iff (reset)
		fire && req_i.op == op_neg && !req_i.byte_op |=>
		rsp_reg.result + $past(req_i.opa) == 16'h0000)
		else $error("negation wrong");
	bit_compare_a: assert property (@(posedge mclk) disable iff (reset)
		fire && req_i.op inside {op_bit_compare_op, op_cmp} |=> !rsp_reg.write_back)
		else $error("compare wrote its operand");
	arith_right_shift_op_sign_a: assert property (@(posedge mclk) disable iff (reset)
		fire && req_i.op == op_arith_right_shift_op |=> rsp_reg.result[15] ==
		$past(req_i.opa[15]))
		else $error("sign bit not kept");
	byte_zero_a: assert property (@(posedge mclk) disable iff (reset)
		fire && req_i.op == op_movbz |=> rsp_reg.result[15:8] == 8'h00 &&
		rsp_reg.flags.zero == (rsp_reg.result == 16'h0000))
		else $error("zero extension or flag wrong");
	busy_ready_a: assert property (@(posedge mclk) disable iff (reset)
		fire && is_div |=> !req_ready[*8])
		else $error("ready during divide");

	cover_add_c: cover property (@(posedge mclk) disable iff (reset)
		fire && req_i.op == op_addc ##1 done_reg);
	cover_divl_c: cover property (@(posedge mclk) disable iff (reset)
		fire && req_i.op == op_divl ##34 done_reg);
	cover_bfld_c: cover property (@(posedge mclk) disable iff (reset)
		fire && req_i.op == op_bfldh ##1 fire);
endmodule : cald_core
`default_nettype wire

// file: core/cald_pkg.sv
// Package: operation codes, request and response carriers and constants
`default_nettype none
package cald_pkg;
	localparam logic [15:0] CALD_RST_WORD  = 16'h0000;
	localparam logic [31:0] CALD_RST_LONG  = 32'h0000_0000;
	localparam logic [4:0]  CALD_DIV_LAST  = 5'h1f;
	localparam logic [3:0]  CALD_SHIFT_MAX = 4'hf;
	localparam logic [15:0] CALD_STEP_ONE  = 16'h0001;
	localparam logic [15:0] CALD_STEP_TWO  = 16'h0002;

	typedef enum logic [5:0] {
		op_add, op_addc, op_sub, op_subc,
		op_mul, op_mulu, op_div, op_divu, op_divl, op_divlu,
		op_cpl, op_neg, op_and, op_or, op_xor,
		op_bclr, op_bset, op_bmov, op_bmovn,
		op_band, op_bor, op_bxor, op_bit_compare_op,
		op_bfldh, op_bfldl,
		op_cmp, op_cmpd1, op_cmpd2, op_cmpi1, op_cmpi2,
		op_prior, op_shl, op_shr, op_rol, op_ror, op_arith_right_shift_op,
		op_mov, op_movbs, op_movbz
	} cald_op_e;

	typedef struct packed {
		logic overflow;
		logic carry;
		logic negative;
		logic zero;
	} cald_flags_s;

	typedef struct packed {
		cald_op_e    op;
		logic        byte_op;
		logic        cin;
		logic [3:0]  dst_bit;
		logic [3:0]  src_bit;
		logic [7:0]  mask;
		logic [7:0]  imm;
		logic [15:0] opa;
		logic [15:0] opb;
		logic [31:0] md_pair;
	} cald_req_s;

	typedef struct packed {
		logic [15:0] result;
		logic [15:0] result_hi;
		cald_flags_s flags;
		logic        write_back;
		logic        hi_valid;
	} cald_rsp_s;
endpackage : cald_pkg
`default_nettype wire

// file: verification/cald_dec_model.sv
// Decoder-side model: presents one request and holds it until it is taken
`default_nettype none
module cald_dec_model
	import cald_pkg::*;
(
	input  wire logic      mclk,
	input  wire logic      reset,
	input  wire logic      start,
	input  wire cald_req_s req_in,
	input  wire logic      req_ready,
	output logic           req_valid,
	output cald_req_s      req_i
);
	timeunit 1ns;
	timeprecision 1ps;

	// A new start may replace a request taken at the same edge
	always_ff @(posedge mclk) begin
		if (reset) begin
			req_valid <= 1'b0;
		end else if (start) begin
			req_valid <= 1'b1;
		end else if (req_valid && req_ready) begin
			req_valid <= 1'b0;
		end
	end

	// Released carrier shows the inverse so a stale value cannot pass
	always_ff @(posedge mclk) begin
		if (start) begin
			req_i <= req_in;
		end else if (req_valid && req_ready) begin
			req_i <= ~req_i;
		end
	end
endmodule : cald_dec_model
`default_nettype wire

// file: verification/cald_core_tb.sv
// Self-checking bench for the arithmetic, logic and bit datapath
`default_nettype none
module cald_core_tb
	import cald_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct packed {
		cald_req_s   r;
		logic [15:0] res;
		logic [3:0]  fl;
		logic [3:0]  fm;
		logic        wb;
		logic        cr;
		logic [15:0] hi;
		logic        hv;
	} cald_row_s;
	logic      mclk;
	logic      reset;
	logic      start;
	logic      req_valid;
	logic      req_ready;
	logic      rsp_valid;
	cald_req_s req_in;
	cald_req_s req_i;
	cald_rsp_s rsp_o;
	cald_row_s rows[$];
	int        failures;
	int        n_checks;
	int        cyc = 0;
	int        take_cyc = 0;

	cald_core i_cald_core (.mclk(mclk), .reset(reset), .req_valid(req_valid),
		.req_i(req_i), .req_ready(req_ready), .rsp_valid(rsp_valid),
		.rsp_o(rsp_o));
	cald_dec_model i_cald_dec_model (.mclk(mclk), .reset(reset),
		.start(start), .req_in(req_in), .req_ready(req_ready),
		.req_valid(req_valid), .req_i(req_i));

	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end

	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (req_valid === 1'b1 && req_ready === 1'b1) begin
			take_cyc <= cyc;
		end
	end

	function automatic cald_req_s m(input cald_op_e op, input logic bo = 0,
		input logic ci = 0, input logic [15:0] a = 0, b = 0,
		input logic [3:0] db = 0, sb = 0, input logic [7:0] mk = 0, im = 0,
		input logic [31:0] md = 0);
		cald_req_s x;
		x = '0;
		x.op = op;
		x.byte_op = bo;
		x.cin = ci;
		x.opa = a;
		x.opb = b;
		x.dst_bit = db;
		x.src_bit = sb;
		x.mask = mk;
		x.imm = im;
		x.md_pair = md;
		return x;
	endfunction : m

	function automatic void q(input cald_req_s r, input logic [15:0] res,
		input logic [3:0] fl, fm = 4'hf, input logic wb = 1, cr = 1,
		input logic [15:0] hi = 0, input logic hv = 0);
		rows.push_back('{r, res, fl, fm, wb, cr, hi, hv});
	endfunction : q

	task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
		n_checks++;
		if (seen !== exp) begin
			failures++;
			$display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic end_sim;
		$display("checks %0d mismatches %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : end_sim

	task automatic lost;
		failures++;
		$display("MISMATCH t=%0t response missing", $time);
		end_sim();
	endtask : lost

	task automatic issue(input cald_req_s r);
		@(posedge mclk);
		start <= 1'b1;
		req_in <= r;
		@(posedge mclk);
		start <= 1'b0;
		#1;
	endtask : issue

	// Reset checked while held, at the release edge and at the edge after it
	task automatic do_reset(input int n);
		@(posedge mclk);
		reset <= 1'b1;
		repeat (n) @(posedge mclk);
		#1;
		chk(req_ready, 0);
		chk(rsp_valid, 0);
		chk(rsp_o, 0);
		@(posedge mclk);
		reset <= 1'b0;
		#1;
		chk(req_ready, 0);
		@(posedge mclk);
		#1;
		chk(req_ready, 1);
		$display("reset test done");
	endtask : do_reset

	task automatic run(input int i);
		int k;
		issue(rows[i].r);
		for (k = 0; k < 60 && rsp_valid !== 1'b1; k++) begin
			@(posedge mclk);
			#1;
		end
		if (k == 60) begin
			lost();
		end
		chk(cyc - take_cyc, (rows[i].r.op inside {op_div, op_divu, op_divl,
			op_divlu}) ? 34 : 1);
		if (rows[i].cr) begin
			chk(rsp_o.result, rows[i].res);
		end
		chk(rsp_o.flags & rows[i].fm, rows[i].fl & rows[i].fm);
		chk(rsp_o.write_back, rows[i].wb);
		chk(rsp_o.hi_valid, rows[i].hv);
		if (rows[i].hv) begin
			chk(rsp_o.result_hi, rows[i].hi);
		end
	endtask : run

	initial begin
		reset = 1'b1;
		start = 1'b0;
		req_in = '0;
		failures = 0;
		n_checks = 0;
		q(m(op_add, 0, 0, 16'hffff, 16'h0001), 16'h0000, 4'h5);
		q(m(op_addc, 0, 1, 16'h7fff), 16'h8000, 4'ha);
		q(m(op_sub, 0, 0, 16'h0000, 16'h0001), 16'hffff, 4'h6);
		q(m(op_subc, 0, 1, 16'h0005, 16'h0003), 16'h0001, 4'h0);
		q(m(op_add, 1, 0, 16'h12ff, 16'h0001), 16'h1200, 4'h5);
		q(m(op_sub, 1, 0, 16'h3480, 16'h0001), 16'h347f, 4'h8);
		q(m(op_mul, 0, 0, 16'hffff, 16'h0002), 16'hfffe, 4'h0, 4'h8, 1, 1,
			16'hffff, 1);
		q(m(op_mulu, 0, 0, 16'h0100, 16'h0100), 16'h0000, 4'h8, 4'h8, 1, 1,
			16'h0001, 1);
		q(m(op_div, 0, 0, 16'hff9c, 16'h0007), 16'hfff2, 4'h0, 4'h8, 1, 1,
			16'hfffe, 1);
		q(m(op_divu, 0, 0, 16'h0064, 16'h0007), 16'h000e, 4'h0, 4'h8, 1, 1,
			16'h0002, 1);
		q(m(op_divl, 0, 0, 0, 16'h0002, 0, 0, 0, 0, 32'hffff_fffc), 16'hfffe,
			4'h0, 4'h8, 1, 1, 16'h0000, 1);
		q(m(op_divlu, 0, 0, 0, 16'h0002, 0, 0, 0, 0, 32'h0001_0000), 16'h8000,
			4'h0, 4'h8, 1, 1, 16'h0000, 1);
		q(m(op_cpl, 0, 0, 16'h00ff, 16'h00ff), 16'hff00, 4'h2);
		q(m(op_neg, 1, 0, 16'h5501, 16'h5501), 16'h55ff, 4'h6);
		q(m(op_and, 0, 0, 16'hf0f0, 16'hff00), 16'hf000, 4'h2);
		q(m(op_or, 0, 0, 16'h0000, 16'h0000), 16'h0000, 4'h1);
		q(m(op_xor, 0, 0, 16'haaaa, 16'hffff), 16'h5555, 4'h0);
		q(m(op_bclr, 0, 0, 16'hffff, 16'hffff, 4), 16'hffef, 4'h0, 4'h0);
		q(m(op_bset, 0, 0, 16'h0000, 16'h0000, 3), 16'h0008, 4'h0, 4'h0);
		q(m(op_bmov, 0, 0, 16'h0000, 16'h0004, 0, 2), 16'h0001, 4'hb);
		q(m(op_bmovn, 0, 0, 16'hffff, 16'h0000, 15), 16'hffff, 4'ha);
		q(m(op_bxor, 0, 0, 16'h0003, 16'h0002, 0, 1), 16'h0002, 4'hc);
		q(m(op_band, 0, 0, 16'h0001, 16'h0000), 16'h0000, 4'ha);
		q(m(op_bit_compare_op, 0, 0, 16'h0001), 16'h0000, 4'ha, 4'hf, 0, 0);
		q(m(op_bfldh, 0, 0, 16'h1234, 0, 0, 0, 8'h0f, 8'hab), 16'h1b34, 4'h0,
			4'h0);
		q(m(op_bfldl, 0, 0, 16'h1234, 0, 0, 0, 8'h0f, 8'hab), 16'h123b, 4'h0,
			4'h0);
		q(m(op_cmp, 0, 0, 16'h0005, 16'h0005), 16'h0, 4'h1, 4'hf, 0, 0);
		q(m(op_cmp, 1, 0, 16'h1200, 16'h3400), 16'h0, 4'h1, 4'hf, 0, 0);
		q(m(op_cmpd1, 0, 0, 16'h0010, 16'h0011), 16'hffff, 4'h6, 4'hf, 1, 1,
			16'h0010 - CALD_STEP_ONE, 1);
		q(m(op_cmpd2, 0, 0, 16'h0010, 16'h0010), 16'h0000, 4'h1, 4'hf, 1, 1,
			16'h0010 - CALD_STEP_TWO, 1);
		q(m(op_cmpi1, 0, 0, 16'h7fff, 16'hffff), 16'h8000, 4'he, 4'hf, 1, 1,
			16'h8000, 1);
		q(m(op_cmpi2, 0, 0, 16'h0001, 16'h0000), 16'h0001, 4'h0, 4'hf, 1, 1,
			16'h0003, 1);
		q(m(op_prior, 0, 0, 16'h0001, 16'h0001), 16'h000f, 4'h0, 4'hc);
		q(m(op_shl, 0, 0, 16'h8001, 16'h0001), 16'h0002, 4'h4);
		q(m(op_shr, 0, 0, 16'h0003, 16'h0001), 16'h0001, 4'h4);
		q(m(op_ror, 0, 0, 16'h0001, 16'h0004), 16'h1000, 4'h0, 4'hc);
		q(m(op_arith_right_shift_op, 0, 0, 16'h8000, 16'h0003), 16'hf000, 4'h2);
		q(m(op_movbs, 0, 0, 16'h0000, 16'h0080), 16'hff80, 4'h0, 4'hd);
		q(m(op_movbz, 0, 0, 16'h0000, 16'h0080), 16'h0080, 4'h0, 4'hd);
		q(m(op_mov, 1, 0, 16'hab00, 16'h00cd), 16'habcd, 4'h2);
		q(m(cald_op_e'(6'h3f)), 16'h0, 4'h0, 4'h0, 0, 0);
		do_reset(12);
		for (int i = 0; i < rows.size(); i++) begin
			run(i);
		end
		$display("table test done");
		// Back to back: second request taken the edge after the first
		@(posedge mclk);
		start <= 1'b1;
		req_in <= rows[1].r;
		@(posedge mclk);
		req_in <= rows[2].r;
		@(posedge mclk);
		start <= 1'b0;
		#1;
		chk(rsp_valid, 1);
		chk(rsp_o.result, rows[1].res);
		@(posedge mclk);
		#1;
		chk(rsp_valid, 1);
		chk(rsp_o.result, rows[2].res);
		$display("back to back test done");
		// An add offered during a divide waits for the quotient
		issue(rows[8].r);
		@(posedge mclk);
		#1;
		chk(req_ready, 0);
		@(posedge mclk);
		start <= 1'b1;
		req_in <= rows[0].r;
		begin : busy
			int k;
			int seen;
			seen = 0;
			for (k = 0; k < 60 && seen < 2; k++) begin
				@(posedge mclk);
				start <= 1'b0;
				#1;
				if (rsp_valid === 1'b1) begin
					seen++;
					chk(cyc - take_cyc, (seen == 1) ? 34 : 1);
					chk(rsp_o.result, rows[seen == 1 ? 8 : 0].res);
				end
			end
			if (seen < 2) begin
				lost();
			end
		end
		$display("busy test done");
		// Reset in mid divide drops the operation
		issue(rows[11].r);
		do_reset(2);
		run(5);
		$display("mid reset test done");
		end_sim();
	end
endmodule : cald_core_tb
`default_nettype wire
